// [hw/pmpsc_controller.sv]
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - Low supply: no-supply state, reset, all off
// - Backup: only oscillator and clock run
// - Off: only oscillator and clock domain supply on
// - Enable conditions met: go active, supplies on
// - Sleep state puts the supplies low-power
// - Enable: no disable and any source
// - Hold input counts unless configured GPI
// - Wake pulse only while system reset is low (off, backup or no-supply state)
// - Pulse only when status bit was clear
// - Cold reset release makes a wake pulse
// - Battery charge and alarm events wake device
// - GPIO pins wake except pin two
// - Watchdog wakes from sleep only
// - Long press disables and sets flag
// - Thermal shutdown flag disables power-on
// - Turn-off bits disable; turn-off self-clears
// - Keep-on bit set turns device back on
// - Sleep needs pin, permit bit, no pending
// - Power-on reset clears all but tick divider, read data and output registers
// - General reset spares status and backup
// - Wake pulse lasts one second
module pmpsc_controller #(
    parameter int WAKE_TICKS = pmpsc_pkg::WAKE_PULSE_TICKS,
    parameter int TICK_DIV   = pmpsc_pkg::TICK_DIV
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire pmpsc_pkg::pmpsc_supply_t supply,
    input  wire logic                    power_button_n,
    input  wire logic                    power_hold_in,
    input  wire logic                    cold_reset_in,
    input  wire logic                    sleep_in,
    input  wire logic                    rtc_alarm_evt,
    input  wire logic                    watchdog_evt,
    input  wire logic [5:0]              gpio_evt,
    output logic                         system_reset_out_n,
    output logic                         irq_out_n,
    output logic                         rtc_domain_on,
    output logic                         osc_rtc_run,
    output logic                         supplies_on,
    output logic                         supplies_low_power,
    output logic                         general_reset
);

    pmpsc_pkg::pmpsc_state_t state_q, state_d;
    logic [7:0]              ctrl_q;
    logic [pmpsc_pkg::IRQ_W-1:0] irq_q, irq_set, mask_q;
    logic [15:0]             lpdly_q, lp_cnt_q;
    logic [15:0]             div_q;
    logic [31:0]             pulse_cnt_q;
    logic                    hrst_q, chg_q, alarm_q, lp_hit_q;
    logic                    pulse_cold_q;
    logic [31:0]             prdata_q;

    // 32 kHz tick from core clock
    wire tick = (div_q == 16'(TICK_DIV - 1));

    // Bus decode
    wire wr_acc = psel & penable & pwrite;
    wire rd_acc = psel & penable & ~pwrite;
    wire addr_ok = (paddr == pmpsc_pkg::CTRL_ADDR) | (paddr == pmpsc_pkg::STATUS_ADDR)
                 | (paddr == pmpsc_pkg::IRQ_ADDR) | (paddr == pmpsc_pkg::MASK_ADDR)
                 | (paddr == pmpsc_pkg::LPDLY_ADDR);
    wire wr_ctrl  = wr_acc & (paddr == pmpsc_pkg::CTRL_ADDR);
    wire wr_irq   = wr_acc & (paddr == pmpsc_pkg::IRQ_ADDR);
    wire wr_mask  = wr_acc & (paddr == pmpsc_pkg::MASK_ADDR);
    wire wr_lpdly = wr_acc & (paddr == pmpsc_pkg::LPDLY_ADDR);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = prdata_q;

    // Event qualification
    wire in_off      = ~system_reset_out_n;
    wire is_on       = (state_q == pmpsc_pkg::PMPSC_ACTIVE)
                     | (state_q == pmpsc_pkg::PMPSC_SLEEP);
    wire chg_event   = supply.battery_high_detect & supply.battery_charge_detect
                     & ~chg_q;
    wire alarm_event = rtc_alarm_evt & ~alarm_q;
    wire hrst_rel    = hrst_q & ~cold_reset_in;
    wire lp_long     = ~power_button_n & ~ctrl_q[pmpsc_pkg::CTRL_LP_DIS]
                     & (lp_cnt_q >= lpdly_q);

    // Sticky event bits
    always_comb begin
        irq_set = '0;
        irq_set[pmpsc_pkg::IRQ_RTC_ALARM]  = alarm_event;
        irq_set[pmpsc_pkg::IRQ_BAT_CHARGE] = chg_event;
        irq_set[pmpsc_pkg::IRQ_LONG_PRESS] = lp_long & ~lp_hit_q;
        irq_set[pmpsc_pkg::IRQ_WATCHDOG]   = watchdog_evt;
        irq_set[pmpsc_pkg::IRQ_GPIO0 +: 6] = gpio_evt;
    end

    // New unmasked wake flag on a previously clear bit only
    wire [pmpsc_pkg::IRQ_W-1:0] fresh = irq_set & ~irq_q & ~mask_q
                                      & pmpsc_pkg::WAKE_SRC_MASK;
    wire start_pulse = in_off & ((|fresh) | hrst_rel);
    wire pulse_on    = (pulse_cnt_q != 32'h0);
    wire pending     = |(irq_q & ~mask_q);
    assign irq_out_n = ~pending;
    // Pulse collapses if software clears status meanwhile
    // A cold reset pulse has no status bit behind it, so it runs its full length
    wire wake_pulse  = pulse_on & (pending | pulse_cold_q);

    // Enable and disable conditions
    wire hold_en    = power_hold_in & ~ctrl_q[pmpsc_pkg::CTRL_HOLD_GPI];
    wire dis_cond   = lp_long | supply.thermal_shutdown_flag
                    | ctrl_q[pmpsc_pkg::CTRL_TURN_OFF]
                    | ctrl_q[pmpsc_pkg::CTRL_OFF_RST];
    wire src_cond   = ~power_button_n | hold_en | ctrl_q[pmpsc_pkg::CTRL_KEEP_ON]
                    | wake_pulse;
    wire on_en      = ~dis_cond & src_cond;
    wire slp_pin    = (sleep_in == ctrl_q[pmpsc_pkg::CTRL_SLP_POL]);
    wire slp_en     = slp_pin & ctrl_q[pmpsc_pkg::CTRL_SLP_PERM] & ~pending;
    wire gen_rst    = ctrl_q[pmpsc_pkg::CTRL_LP_RST] | ctrl_q[pmpsc_pkg::CTRL_OFF_RST]
                    | cold_reset_in;

    // Next state
    always_comb begin
        state_d = state_q;
        if (!supply.supply_rtc_ok) begin
            state_d = pmpsc_pkg::PMPSC_NO_SUPPLY;
        end else if (!supply.supply_on_ok) begin
            state_d = pmpsc_pkg::PMPSC_BACKUP;
        end else if (tick) begin
            unique case (state_q)
                pmpsc_pkg::PMPSC_NO_SUPPLY,
                pmpsc_pkg::PMPSC_BACKUP: begin
                    state_d = pmpsc_pkg::PMPSC_OFF;
                end
                // Off waits for any enable source with no disable
                pmpsc_pkg::PMPSC_OFF: begin
                    if (on_en) begin
                        state_d = pmpsc_pkg::PMPSC_ACTIVE;
                    end
                end
                // Disable wins over a sleep request
                pmpsc_pkg::PMPSC_ACTIVE: begin
                    if (!on_en) begin
                        state_d = pmpsc_pkg::PMPSC_OFF;
                    end else if (slp_en) begin
                        state_d = pmpsc_pkg::PMPSC_SLEEP;
                    end
                end
                // Pending unmasked flag or pin change ends sleep
                pmpsc_pkg::PMPSC_SLEEP: begin
                    if (!on_en) begin
                        state_d = pmpsc_pkg::PMPSC_OFF;
                    end else if (!slp_en) begin
                        state_d = pmpsc_pkg::PMPSC_ACTIVE;
                    end
                end
                default: state_d = pmpsc_pkg::PMPSC_NO_SUPPLY;
            endcase
        end
    end

    // Full reset from power-on reset or asynchronous rst
    wire por = supply.por_threshold;

    // Tick divider
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q <= 16'h0;
        end else if (tick) begin
            div_q <= 16'h0;
        end else begin
            div_q <= div_q + 16'h1;
        end
    end

    // State register; power-on reset restarts from no supply
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= pmpsc_pkg::PMPSC_NO_SUPPLY;
        end else if (por) begin
            state_q <= pmpsc_pkg::PMPSC_NO_SUPPLY;
        end else begin
            state_q <= state_d;
        end
    end

    // Control register; turn-off bit clears in off state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= pmpsc_pkg::CTRL_RESET;
        end else if (por || (gen_rst && !wr_ctrl)) begin
            ctrl_q <= pmpsc_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0];
        end else if (state_q == pmpsc_pkg::PMPSC_OFF) begin
            ctrl_q[pmpsc_pkg::CTRL_TURN_OFF] <= 1'b0;
        end
    end

    // Status, mask, delay; general reset leaves status alone
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_q   <= '0;
            mask_q  <= pmpsc_pkg::MASK_RESET;
            lpdly_q <= pmpsc_pkg::LPDLY_RESET;
        end else if (por) begin
            irq_q   <= '0;
            mask_q  <= pmpsc_pkg::MASK_RESET;
            lpdly_q <= pmpsc_pkg::LPDLY_RESET;
        end else begin
            // Set wins over write-one-to-clear
            irq_q <= (irq_q & ~(wr_irq ? pwdata[pmpsc_pkg::IRQ_W-1:0] : '0)) | irq_set;
            if (wr_mask)  mask_q  <= pwdata[pmpsc_pkg::IRQ_W-1:0];
            if (wr_lpdly) lpdly_q <= pwdata[15:0];
        end
    end

    // Edge trackers each cycle, long-press counter on tick
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrst_q   <= 1'b0;
            chg_q    <= 1'b0;
            alarm_q  <= 1'b0;
            lp_hit_q <= 1'b0;
            lp_cnt_q <= 16'h0;
        end else if (por) begin
            // Full reset also forgets edges and the first-charge history
            hrst_q   <= 1'b0;
            chg_q    <= 1'b0;
            alarm_q  <= 1'b0;
            lp_hit_q <= 1'b0;
            lp_cnt_q <= 16'h0;
        end else begin
            hrst_q   <= cold_reset_in;
            chg_q    <= chg_q | (supply.battery_high_detect & supply.battery_charge_detect);
            alarm_q  <= rtc_alarm_evt;
            lp_hit_q <= lp_long;
            if (power_button_n) lp_cnt_q <= 16'h0;
            else if (tick && lp_cnt_q != 16'hffff) lp_cnt_q <= lp_cnt_q + 16'h1;
        end
    end

    // Wake pulse timer, counted in 32 kHz ticks
    // Cold reset pulses are not cut short by a status clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pulse_cnt_q  <= 32'h0;
            pulse_cold_q <= 1'b0;
        end else if (por) begin
            pulse_cnt_q  <= 32'h0;
            pulse_cold_q <= 1'b0;
        end else if (start_pulse) begin
            pulse_cnt_q  <= 32'(WAKE_TICKS);
            pulse_cold_q <= hrst_rel;
        end else if (!pending && !pulse_cold_q) begin
            pulse_cnt_q  <= 32'h0;
        end else if (tick && pulse_on) begin
            pulse_cnt_q  <= pulse_cnt_q - 32'h1;
        end
    end

    // Read mux
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0;
        end else if (rd_acc) begin
            unique case (paddr)
                pmpsc_pkg::CTRL_ADDR:   prdata_q <= {24'h0, ctrl_q};
                pmpsc_pkg::STATUS_ADDR: prdata_q <= {25'h0, wake_pulse, on_en, 5'(state_q)};
                pmpsc_pkg::IRQ_ADDR:    prdata_q <= {22'h0, irq_q};
                pmpsc_pkg::MASK_ADDR:   prdata_q <= {22'h0, mask_q};
                pmpsc_pkg::LPDLY_ADDR:  prdata_q <= {16'h0, lpdly_q};
                default:                prdata_q <= 32'h0;
            endcase
        end
    end

    // Power outputs per state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            system_reset_out_n <= 1'b0;
            rtc_domain_on      <= 1'b0;
            osc_rtc_run        <= 1'b0;
            supplies_on        <= 1'b0;
            supplies_low_power <= 1'b0;
            general_reset      <= 1'b0;
        end else begin
            system_reset_out_n <= is_on;
            rtc_domain_on      <= (state_q != pmpsc_pkg::PMPSC_NO_SUPPLY);
            osc_rtc_run        <= (state_q != pmpsc_pkg::PMPSC_NO_SUPPLY);
            supplies_on        <= is_on;
            supplies_low_power <= (state_q == pmpsc_pkg::PMPSC_SLEEP);
            general_reset      <= gen_rst;
        end
    end

endmodule // pmpsc_controller

// [hw/pmpsc_pkg.sv]
package pmpsc_pkg;

    // Controller states, one-hot
    typedef enum logic [4:0] {
        PMPSC_NO_SUPPLY = 5'h01,
        PMPSC_BACKUP    = 5'h02,
        PMPSC_OFF       = 5'h04,
        PMPSC_ACTIVE    = 5'h08,
        PMPSC_SLEEP     = 5'h10
    } pmpsc_state_t;

    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] IRQ_ADDR    = 8'h08;
    localparam logic [7:0] MASK_ADDR   = 8'h0c;
    localparam logic [7:0] LPDLY_ADDR  = 8'h10;

    // Control register field positions
    localparam int CTRL_KEEP_ON   = 0;
    localparam int CTRL_TURN_OFF  = 1;
    localparam int CTRL_OFF_RST   = 2;
    localparam int CTRL_SLP_PERM  = 3;
    localparam int CTRL_SLP_POL   = 4;
    localparam int CTRL_HOLD_GPI  = 5;
    localparam int CTRL_LP_DIS    = 6;
    localparam int CTRL_LP_RST    = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Interrupt status bit positions
    localparam int IRQ_RTC_ALARM  = 0;
    localparam int IRQ_BAT_CHARGE = 1;
    localparam int IRQ_LONG_PRESS = 2;
    localparam int IRQ_WATCHDOG   = 3;
    localparam int IRQ_GPIO0      = 4;
    localparam int IRQ_W          = 10;
    // Sources allowed to cause turn-on: all except watchdog and GPIO pin 2
    localparam logic [IRQ_W-1:0] WAKE_SRC_MASK = 10'h3b7;
    localparam logic [IRQ_W-1:0] MASK_RESET    = 10'h3ff;

    // Timing: 32 kHz tick from 125 MHz, pulse 1 s
    localparam int CLK_HZ          = 125_000_000;
    localparam int TICK_HZ         = 32_768;
    localparam int TICK_DIV        = CLK_HZ / TICK_HZ;
    localparam int WAKE_PULSE_MS   = 1000;
    // Whole ticks per pulse; multiply first so a 1 s pulse is a full second of ticks
    localparam int WAKE_PULSE_TICKS = (TICK_HZ * WAKE_PULSE_MS) / 1000;
    localparam logic [15:0] LPDLY_RESET = 16'h2000;

    // Analog and pin inputs grouped
    typedef struct packed {
        logic supply_rtc_ok;
        logic supply_on_ok;
        logic battery_high_detect;
        logic battery_charge_detect;
        logic por_threshold;
        logic thermal_shutdown_flag;
    } pmpsc_supply_t;

endpackage

// [sim/pmpsc_chk.sv]
`timescale 1ns/1ps
module pmpsc_chk (
    input wire logic                     core_clk,
    input wire logic                     rst,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic [7:0]               paddr,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire pmpsc_pkg::pmpsc_supply_t supply,
    input wire logic                     cold_reset_in,
    input wire logic                     irq_out_n,
    input wire logic                     system_reset_out_n,
    input wire logic                     rtc_domain_on,
    input wire logic                     supplies_on,
    input wire logic                     supplies_low_power,
    input wire logic                     general_reset
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Bus answers at once and flags unmapped places
    bus_ready_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    bad_addr_a: assert property (psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04,
        8'h08, 8'h0c, 8'h10})) else $error("pslverr wrong for address");
    // Rails and resets against supplies, heat, interrupts and resets
    nosup_off_a: assert property (!supply.supply_rtc_ok [*8] |-> !supplies_on && !system_reset_out_n)
        else $error("rails on without supply");
    backup_off_a: assert property (!supply.supply_on_ok [*8] |-> !supplies_on && !supplies_low_power)
        else $error("rails on in backup");
    rtc_dom_on_a: assert property ((supply.supply_rtc_ok && supply.supply_on_ok) [*8]
        |-> ##[0:8] rtc_domain_on) else $error("clock domain supply off");
    thermal_off_a: assert property (supply.thermal_shutdown_flag [*8] |-> !supplies_on)
        else $error("rails on while too hot");
    sleep_irq_a: assert property (!irq_out_n [*8] |-> !supplies_low_power)
        else $error("sleep with pending interrupt");
    por_clear_a: assert property (supply.por_threshold [*2] |-> !supplies_on && !system_reset_out_n)
        else $error("outputs alive in power-on reset");
    cold_gen_a: assert property (cold_reset_in [*8] |-> general_reset)
        else $error("no general reset on cold reset");
    // Main scenarios
    cover property ($rose(supplies_low_power));
    cover property ($rose(supplies_on));
    cover property ($rose(general_reset));
endmodule // pmpsc_chk

bind pmpsc_controller pmpsc_chk pmpsc_chk_inst (.core_clk, .rst, .psel, .penable, .paddr,
    .pready, .pslverr, .supply, .cold_reset_in, .irq_out_n, .system_reset_out_n, .rtc_domain_on,
    .supplies_on, .supplies_low_power, .general_reset);

// [sim/pmpsc_host_pins.sv]
`timescale 1ns/1ps
module pmpsc_host_pins (
    input  wire logic core_clk,
    output logic      power_button_n,
    output logic      power_hold_in,
    output logic      sleep_in,
    output logic      cold_reset_in
);
    // Released pins: button up, no hold, sleep pin inactive
    initial begin
        power_button_n = 1'b1;
        power_hold_in = 1'b0;
        sleep_in = 1'b1;
        cold_reset_in = 1'b0;
    end
    // Host changes its pins just after a rising edge
    task automatic drive(logic b, logic h, logic s, logic c);
        @(posedge core_clk);
        power_button_n <= b;
        power_hold_in <= h;
        sleep_in <= s;
        cold_reset_in <= c;
    endtask
endmodule // pmpsc_host_pins

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, rd_err, rtc_alarm_evt;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    pmpsc_pkg::pmpsc_supply_t supply;
    logic power_button_n, power_hold_in, cold_reset_in, sleep_in, watchdog_evt, irq_out_n;
    logic [5:0] gpio_evt;
    logic system_reset_out_n, rtc_domain_on, osc_rtc_run, supplies_on, supplies_low_power;
    logic general_reset;
    int failures, checks_done, ctrl_m, wake, pend, src, r, lp;
    pmpsc_controller #(.WAKE_TICKS(4), .TICK_DIV(4)) pmpsc_controller_inst (.core_clk, .rst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supply,
        .power_button_n, .power_hold_in, .cold_reset_in, .sleep_in, .rtc_alarm_evt,
        .watchdog_evt, .gpio_evt, .system_reset_out_n, .irq_out_n, .rtc_domain_on,
        .osc_rtc_run, .supplies_on, .supplies_low_power, .general_reset);
    pmpsc_host_pins pmpsc_host_pins_inst (.core_clk, .power_button_n, .power_hold_in,
        .sleep_in, .cold_reset_in);
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One transfer, held until pready at a rising edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
    endtask
    task automatic rel();
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1, a, d);
        rel();
        if (a == pmpsc_pkg::CTRL_ADDR) ctrl_m = d;
    endtask
    // Read data is registered, so the same place is read twice
    task automatic rd(logic [7:0] a);
        apb(0, a, 0);
        apb(0, a, 0);
        rel();
    endtask
    // Reference state from pins, supplies and shadow control bits
    function automatic logic [4:0] mst();
        logic en, dis;
        if (!supply.supply_rtc_ok) return 5'h01;
        if (!supply.supply_on_ok) return 5'h02;
        dis = supply.thermal_shutdown_flag | ctrl_m[1] | ctrl_m[2] | lp;
        en = !power_button_n | (power_hold_in & !ctrl_m[5]) | ctrl_m[0] | wake;
        if (dis | !en) return 5'h04;
        if (sleep_in == ctrl_m[4] && ctrl_m[3] && !pend) return 5'h10;
        return 5'h08;
    endfunction
    task automatic wait_st(string what);
        for (int i = 0; i < 64; i++) begin
            rd(pmpsc_pkg::STATUS_ADDR);
            if (rd_data[4:0] === mst()) break;
        end
        chk(what, mst(), rd_data[4:0]);
    endtask
    task automatic pulse(int s);
        if (s == 6) rtc_alarm_evt <= 1;
        else if (s == 7) watchdog_evt <= 1;
        else gpio_evt[s] <= 1;
        @(posedge core_clk);
        rtc_alarm_evt <= 0;
        watchdog_evt <= 0;
        gpio_evt <= 0;
        @(posedge core_clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        end_of_test();
    end
    initial begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; supply = '0;
        rtc_alarm_evt = 0; watchdog_evt = 0; gpio_evt = 0;
        failures = 0; checks_done = 0; ctrl_m = 0; wake = 0; pend = 0; lp = 0;
        void'($urandom(86631));
        repeat (16) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        rd(pmpsc_pkg::CTRL_ADDR); chk("ctrl", 0, rd_data);
        rd(pmpsc_pkg::MASK_ADDR); chk("mask", 32'h3ff, rd_data);
        rd(pmpsc_pkg::LPDLY_ADDR); chk("lpdly", 32'h2000, rd_data);
        rd(8'h14); chk("slverr", 1, rd_err);
        wait_st("nosupply");
        supply.supply_rtc_ok <= 1; wait_st("backup");
        chk("osc", 1, osc_rtc_run);
        supply.supply_on_ok <= 1; wait_st("off");
        chk("rtc dom", 1, rtc_domain_on);
        $display("test supplies done");
        pmpsc_host_pins_inst.drive(1, 1, 1, 0); wait_st("hold");
        chk("rails", 1, supplies_on);
        wr(pmpsc_pkg::CTRL_ADDR, 32'h20); wait_st("hold gpi");
        wr(pmpsc_pkg::CTRL_ADDR, 0);
        pmpsc_host_pins_inst.drive(0, 0, 1, 0); wait_st("button");
        pmpsc_host_pins_inst.drive(1, 0, 1, 0); wait_st("released");
        wr(pmpsc_pkg::LPDLY_ADDR, 3); pmpsc_host_pins_inst.drive(0, 0, 1, 0); lp = 1;
        repeat (40) @(posedge core_clk);
        wait_st("long press");
        rd(pmpsc_pkg::IRQ_ADDR); chk("lp flag", 4, rd_data & 32'h4);
        pmpsc_host_pins_inst.drive(1, 0, 1, 0); lp = 0; wr(pmpsc_pkg::IRQ_ADDR, 4);
        wr(pmpsc_pkg::LPDLY_ADDR, 32'h2000); wait_st("lp released");
        wr(pmpsc_pkg::CTRL_ADDR, 1); wait_st("keep on");
        wr(pmpsc_pkg::CTRL_ADDR, 3); ctrl_m = 1;
        repeat (12) @(posedge core_clk);
        rd(pmpsc_pkg::CTRL_ADDR); chk("ctrl", 1, rd_data);
        wait_st("back on");
        $display("test enables done");
        wr(pmpsc_pkg::CTRL_ADDR, 9); pmpsc_host_pins_inst.drive(1, 0, 0, 0);
        wait_st("sleep");
        chk("low power", 1, supplies_low_power);
        wr(pmpsc_pkg::MASK_ADDR, 32'h3f7); pulse(7); pend = 1;
        wait_st("watchdog");
        wr(pmpsc_pkg::IRQ_ADDR, 32'h3ff); pend = 0; wait_st("resleep");
        pmpsc_host_pins_inst.drive(1, 0, 1, 0); wr(pmpsc_pkg::MASK_ADDR, 32'h3ff);
        supply.thermal_shutdown_flag <= 1; wait_st("thermal");
        supply.thermal_shutdown_flag <= 0; wait_st("cool");
        wr(pmpsc_pkg::CTRL_ADDR, 0); wait_st("off");
        $display("test sleep done");
        r = $urandom_range(6, 0);
        for (int k = 0; k < 7; k++) begin
            src = (k + r) % 7;
            wr(pmpsc_pkg::MASK_ADDR, ~(32'h1 << (src == 6 ? 0 : src + 4)) & 32'h3ff);
            pulse(src); wake = (src != 2);
            wait_st("wake");
            wake = 0; wait_st("pulse end");
            pulse(src);
            repeat (20) @(posedge core_clk);
            wait_st("pending");
            wr(pmpsc_pkg::IRQ_ADDR, 32'h3ff);
        end
        $display("test wake done");
        pmpsc_host_pins_inst.drive(1, 0, 1, 1);
        repeat (12) @(posedge core_clk);
        chk("general reset", 1, general_reset);
        pmpsc_host_pins_inst.drive(1, 0, 1, 0); wake = 1; wait_st("cold wake");
        wake = 0; wait_st("cold end");
        wr(pmpsc_pkg::MASK_ADDR, 0); supply.por_threshold <= 1;
        repeat (4) @(posedge core_clk);
        supply.por_threshold <= 0;
        rd(pmpsc_pkg::MASK_ADDR); chk("mask", 32'h3ff, rd_data);
        wait_st("after por");
        $display("test resets done");
        end_of_test();
    end
endmodule // tb_top
